// ### shared/sync_ctrl_defs.vh
// Purpose: shared constants for the select decode and modem control block
// Assumes: included by bare name from the design files
// Notes: definitions only, no logic
`ifndef SYNC_CTRL_DEFS_VH
`define SYNC_CTRL_DEFS_VH

// select address and the address bits wired to the four-input AND
`define SEL_ADDR 8'hC3
`define SEL_MASK 8'hC3
// all-ones pattern a host reads from an undriven input bus
`define OPEN_BUS 8'hFF

// control-flags byte field positions
`define CTL_DTR_BIT 4
`define CTL_RTS_BIT 5

// status-flags byte field positions
`define STS_DSR_BIT 0
`define STS_DSR_ALT_BIT 1
`define STS_NOT_BUSY_BIT 7

// reset values
`define RST_CTL_FLAGS 8'h00
`define RST_DTR 1'b0
`define RST_RTS 1'b0
`define RST_SELECTED 1'b0
`define RST_READ_DATA 8'hFF
`define RST_SYNC_LEVEL 1'b0

// line levels
`define MARK_LEVEL 1'b1

// cycles from a status read strobe to the answer on the bus
`define READ_ANSWER_CYCLES 1
// length of the synchroniser chain on pin inputs
`define SYNC_STAGES 3

`endif

// ### rtl/pin_sync3.v
// Purpose: brings a pin level into the clk domain
// Assumes: one clock, synchronous active-low reset, clock enable
// Notes: a change is taken once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
`include "sync_ctrl_defs.vh"

module pin_sync3
(
   input wire clk,
   input wire rst_b,
   input wire ce,
   input wire pin,
   output reg level
);

   reg stage1;
   reg stage2;
   reg stage3;

   // three-flop chain; stage1 is read only by stage2
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         stage1 <= `RST_SYNC_LEVEL;
         stage2 <= `RST_SYNC_LEVEL;
         stage3 <= `RST_SYNC_LEVEL;
      end
      else if (ce)
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // accepted level only moves when the two late stages agree
   always @(posedge clk)
   begin
      if (!rst_b)
         level <= `RST_SYNC_LEVEL;
      else if (ce && (stage2 == stage3))
         level <= stage3;
   end

endmodule
`default_nettype wire

// ### rtl/sync_comm_select_modem_ctrl.v
// Purpose: device select decode, status/control flag bytes and static modem lines
// Assumes: host strobes are one-cycle pulses on clk; modem inputs are async pins
// Notes: transmit/receive data paths live elsewhere; tx_serial_bit feeds the line
`timescale 1ns/1ps
`default_nettype none
`include "sync_ctrl_defs.vh"

// Functional notes
// - Respond to the select address hexadecimal C3.
// - Select through a four-input AND of address bits; others stay unselected.
// - Unselected, leave the input bus undriven so status reads return FF.
// - INIT deselects; status reads return open bus until selected again.
// - Control-flags write bit 4 sets or clears Data Terminal Ready.
// - INIT or device clear alone clears Data Terminal Ready.
// - Status-flags byte reports the Data Set Ready input level.
// - INIT and device clear both clear Request To Send.
// - No transmission and Request To Send clear: hold Transmitted Data at mark.
module sync_comm_select_modem_ctrl
(
   input wire clk,
   input wire rst_b,
   input wire ce,
   // host processor i/o bus
   input wire select_strobe,
   input wire [7:0] select_addr,
   input wire status_flags_read,
   input wire control_flags_write,
   input wire [7:0] control_flags_data,
   input wire init,
   input wire device_clear_command,
   output reg [7:0] status_data,
   output reg status_data_oe,
   output reg selected,
   // transmit path hand-off, same clock
   input wire tx_active,
   input wire tx_serial_bit,
   // modem side
   input wire dsr_pin,
   output reg dtr,
   output reg rts,
   output reg txd
);

   // address bits tied to the select gate
   function addr_selects;
      input [7:0] addr;
      begin
         addr_selects = ((addr & `SEL_MASK) == `SEL_MASK);
      end
   endfunction

   // select byte nibble test: upper nibble ORed with lower nibble must be all ones
   function nibbles_full;
      input [7:0] addr;
      begin
         nibbles_full = ((addr[7:4] | addr[3:0]) == 4'hF);
      end
   endfunction

   // priority of one control line: a clear beats a write, otherwise hold
   function ctl_bit_next;
      input hold;
      input clear;
      input write;
      input wdata;
      begin
         if (clear)
         begin
            ctl_bit_next = 1'b0;
         end
         else if (write)
         begin
            ctl_bit_next = wdata;
         end
         else
         begin
            ctl_bit_next = hold;
         end
      end
   endfunction

   // status byte: not-busy high while idle, dsr on both candidate bits
   function [7:0] status_byte_of;
      input not_busy;
      input dsr;
      begin
         status_byte_of = 8'h00;
         status_byte_of[`STS_NOT_BUSY_BIT] = not_busy;
         status_byte_of[`STS_DSR_BIT] = dsr;
         status_byte_of[`STS_DSR_ALT_BIT] = dsr;
      end
   endfunction

   wire dsr_level;
   wire addr_hit;
   wire do_write;
   wire do_read;
   wire clear_by_init;
   wire clear_by_device;
   wire line_clear;
   wire [7:0] status_byte;

   reg [7:0] line_control_flags;
   reg next_selected;
   reg next_dtr;
   reg next_rts;
   reg next_txd;
   reg [7:0] next_status_data;
   reg next_status_data_oe;

   // data set ready comes from the modem and must be synchronised
   pin_sync3 u_pin_sync3
   (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .pin(dsr_pin),
      .level(dsr_level)
   );

   // decode of the select byte; a byte failing the nibble test never selects
   assign addr_hit = nibbles_full(select_addr) && addr_selects(select_addr);

   // bus actions are gated by the current selection
   assign do_write = control_flags_write && selected && !init;
   assign do_read = status_flags_read && selected && !init;

   // init always clears; a device clear only counts for this controller
   assign clear_by_init = init;
   assign clear_by_device = device_clear_command && selected;
   assign line_clear = clear_by_init || clear_by_device;

   // status byte assembled from the live line state
   assign status_byte = status_byte_of(!tx_active, dsr_level);

   // selection follows each select strobe, init drops it
   always @*
   begin
      next_selected = selected;
      if (init)
      begin
         next_selected = 1'b0;
      end
      else if (select_strobe)
      begin
         next_selected = addr_hit;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
         selected <= `RST_SELECTED;
      else if (ce)
         selected <= next_selected;
   end

   // stored copy of the last accepted control byte
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         line_control_flags <= `RST_CTL_FLAGS;
      end
      else if (ce)
      begin
         if (line_clear)
         begin
            line_control_flags <= `RST_CTL_FLAGS;
         end
         else if (do_write)
         begin
            line_control_flags <= control_flags_data;
         end
      end
   end

   // data terminal ready: written by bit 4, cleared by init or device clear
   always @*
   begin
      next_dtr = ctl_bit_next(
         line_control_flags[`CTL_DTR_BIT], // held copy of the last control byte
         line_clear,
         do_write,
         control_flags_data[`CTL_DTR_BIT]
      );
   end

   always @(posedge clk)
   begin
      if (!rst_b)
         dtr <= `RST_DTR;
      else if (ce)
         dtr <= next_dtr;
   end

   // request to send: a transfer raises it, a control write may too
   always @*
   begin
      next_rts = ctl_bit_next(
         rts,
         line_clear,
         do_write,
         control_flags_data[`CTL_RTS_BIT]
      );
      if (tx_active && !line_clear && !do_write)
      begin
         next_rts = 1'b1;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
         rts <= `RST_RTS;
      else if (ce)
         rts <= next_rts;
   end

   // transmitted data sits at mark unless a send is under way
   always @*
   begin
      next_txd = `MARK_LEVEL;
      if (next_rts && tx_active)
      begin
         next_txd = tx_serial_bit;
      end
      else
      begin
         next_txd = `MARK_LEVEL;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
         txd <= `MARK_LEVEL;
      else if (ce)
         txd <= next_txd;
   end

   // status read answer one cycle after the strobe, open bus when unselected
   always @*
   begin
      next_status_data = `OPEN_BUS;
      next_status_data_oe = 1'b0;
      if (do_read)
      begin
         next_status_data = status_byte;
         next_status_data_oe = 1'b1;
      end
      else
      begin
         next_status_data = `OPEN_BUS;
         next_status_data_oe = 1'b0;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         status_data <= `RST_READ_DATA;
         status_data_oe <= 1'b0;
      end
      else if (ce)
      begin
         status_data <= next_status_data;
         status_data_oe <= next_status_data_oe;
      end
   end

endmodule
`default_nettype wire

// ### bench/modem_loop.sv
// Purpose: modem stand-in looping terminal ready back to set ready
// Assumes: loop-back cable, one clock
// Notes: answers two cycles late, like a slow modem
`timescale 1ns/1ps
`default_nettype none
module modem_loop
(
   input wire logic clk,
   input wire logic dtr,
   output var logic dsr_pin
);
   logic lag;
   // two-stage lag from terminal ready to the set-ready pin
   initial
   begin
      lag = 1'b0;
      dsr_pin = 1'b0;
   end
   always @(posedge clk)
   begin
      lag <= dtr;
      dsr_pin <= lag;
   end
endmodule
`default_nettype wire

// ### bench/sync_comm_chk.sv
// Purpose: port assertions for select decode and modem lines
// Assumes: one clock, synchronous active-low reset, ce high
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module sync_comm_chk
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic select_strobe,
   input wire logic [7:0] select_addr,
   input wire logic status_flags_read,
   input wire logic control_flags_write,
   input wire logic [7:0] control_flags_data,
   input wire logic init,
   input wire logic device_clear_command,
   input wire logic [7:0] status_data,
   input wire logic status_data_oe,
   input wire logic selected,
   input wire logic tx_active,
   input wire logic dtr,
   input wire logic rts,
   input wire logic txd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // select, read and control relations
   AST_SEL_OK: assert property (select_strobe && select_addr == 8'hC3 && !init |=> selected)
      else $error("good address ignored");
   AST_SEL_BAD: assert property (select_strobe && (select_addr[7:4] | select_addr[3:0]) != 4'hF |=> !selected)
      else $error("bad address selected");
   AST_OPEN: assert property (!status_data_oe |-> status_data == 8'hFF)
      else $error("undriven bus not FF");
   AST_INIT: assert property (init |=> !selected)
      else $error("init kept selection");
   AST_READ: assert property (status_flags_read |=> status_data_oe == $past(selected && !init))
      else $error("read drive wrong");
   AST_DTR: assert property (control_flags_write && selected && !init && !device_clear_command |=> dtr == $past(control_flags_data[4]))
      else $error("dtr not written");
   AST_CLR: assert property ((init || device_clear_command && selected) && !tx_active |=> !dtr && !rts)
      else $error("clear missed");
   AST_MARK: assert property (!rts && !tx_active |=> txd)
      else $error("txd not mark");
endmodule
bind sync_comm_select_modem_ctrl sync_comm_chk u_sync_comm_chk(.clk(clk), .rst_b(rst_b),
   .select_strobe(select_strobe), .select_addr(select_addr), .status_flags_read(status_flags_read),
   .control_flags_write(control_flags_write), .control_flags_data(control_flags_data), .init(init),
   .device_clear_command(device_clear_command), .status_data(status_data), .status_data_oe(status_data_oe),
   .selected(selected), .tx_active(tx_active), .dtr(dtr), .rts(rts), .txd(txd));
`default_nettype wire

// ### bench/tb_sync_comm_select_modem_ctrl.sv
// Purpose: bench for select decode and modem lines
// Assumes: ce high, transmission only driven in the transmit test
// Notes: modem loops terminal ready back to set ready
`timescale 1ns/1ps
`default_nettype none
module tb_sync_comm_select_modem_ctrl;
   logic clk, rst_b, ss, rd, wr, ini, dc, dsr, oe, sel, dtr, rts, txd, tx, txb;
   logic [7:0] sa, wd, sd;
   int mismatches, checked;
   sync_comm_select_modem_ctrl u_sync_comm_select_modem_ctrl(.clk(clk), .rst_b(rst_b), .ce(1'b1),
      .select_strobe(ss), .select_addr(sa), .status_flags_read(rd), .control_flags_write(wr),
      .control_flags_data(wd), .init(ini), .device_clear_command(dc), .status_data(sd),
      .status_data_oe(oe), .selected(sel), .tx_active(tx), .tx_serial_bit(txb), .dsr_pin(dsr),
      .dtr(dtr), .rts(rts), .txd(txd));
   modem_loop u_modem_loop(.clk(clk), .dtr(dtr), .dsr_pin(dsr));
   // clock
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task pick(input logic [7:0] a);
      ss <= 1;
      sa <= a;
      tick(1);
      ss <= 0;
      tick(1);
   endtask
   task read(input logic [7:0] e);
      rd <= 1;
      tick(1);
      rd <= 0;
      #1 chk(sd, e);
      chk(oe, e !== 8'hFF);
      tick(1);
   endtask
   task put(input logic [7:0] d);
      wr <= 1;
      wd <= d;
      tick(1);
      wr <= 0;
      tick(1);
   endtask
   task hit(input logic i);
      ini <= i;
      dc <= !i;
      tick(1);
      ini <= 0;
      dc <= 0;
      tick(1);
   endtask
   task t_select;
      logic [7:0] bad [4] = '{8'h00, 8'h5A, 8'hC2, 8'h83};
      foreach (bad[i])
      begin
         pick(bad[i]);
         read(8'hFF);
      end
      pick(8'hC3);
      read(8'h80);
      hit(1);
      read(8'hFF);
      chk(sel, 0);
      $display("select test done");
   endtask
   task t_flags;
      put(8'h10);
      chk(dtr, 0);
      pick(8'hC3);
      put(8'h10);
      chk(dtr, 1);
      tick(10);
      read(8'h83);
      put(8'h00);
      chk(dtr, 0);
      tick(10);
      read(8'h80);
      $display("flags test done");
   endtask
   task t_clear;
      for (int i = 0; i < 2; i++)
      begin
         pick(8'hC3);
         put(8'h30);
         chk({rts, dtr}, 2'b11);
         hit(i[0]);
         chk({rts, dtr, txd}, 3'b001);
      end
      $display("clear test done");
   endtask
   task t_reset;
      pick(8'hC3);
      put(8'h30);
      rst_b <= 0;
      tick(4);
      rst_b <= 1;
      #1 chk({sel, dtr, rts, txd, oe}, 5'h02);
      chk(sd, 8'hFF);
      tick(1);
      $display("reset test done");
   endtask
   task t_tx;
      pick(8'hC3);
      tx <= 1;
      txb <= 0;
      read(8'h00);
      chk({rts, txd}, 2'b10);
      txb <= 1;
      tick(2);
      chk(txd, 1);
      ini <= 1;
      tick(1);
      ini <= 0;
      #1 chk({sel, rts, txd}, 3'b001);
      tick(1);
      tx <= 0;
      pick(8'hC3);
      dc <= 1;
      tick(1);
      dc <= 0;
      #1 chk({rts, txd}, 2'b01);
      repeat (8)
      begin
         tick(1);
         chk({rts, txd}, 2'b01);
      end
      read(8'h80);
      $display("transmit test done");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      rst_b = 0;
      {ss, rd, wr, ini, dc, tx, txb} = 7'h00;
      sa = 8'h00;
      wd = 8'h00;
      tick(10);
      rst_b <= 1;
      tick(1);
      t_select;
      t_flags;
      t_clear;
      t_reset;
      t_tx;
      print_verdict;
   end
   // watchdog
   initial
   begin
      #5000;
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
